// file: design/etf_pkg.sv
// constants and types shared by the telemetry framer
package etf_pkg;
  localparam int SEQ_W = 14;
  localparam logic [SEQ_W-1:0] SEQ_RST = 14'h0000;
  localparam logic [SEQ_W-1:0] SEQ_MAX = 14'h3FFF;
  // packet id bytes: event category and dump category
  localparam logic [7:0] EVT_ID_HI = 8'h0D;
  localparam logic [7:0] EVT_ID_LO = 8'h17;
  localparam logic [7:0] DMP_ID_HI = 8'h0B;
  localparam logic [7:0] DMP_ID_LO = 8'hB9;
  localparam logic [1:0] SEQ_FLAGS = 2'h3;
  // data field header
  localparam logic [7:0] DFH_PUS = 8'h40;
  localparam logic [7:0] DFH_SPARE = 8'h00;
  localparam logic [7:0] EVT_SVC = 8'h05;
  localparam logic [7:0] EVT_SUB = 8'h02;
  localparam logic [7:0] DMP_SVC = 8'h06;
  localparam logic [7:0] DMP_SUB = 8'h06;
  localparam logic [3:0] HDR_LAST = 4'hF;
  localparam logic [15:0] DFH_LEN = 16'h000A;
  localparam logic [15:0] EID_LEN = 16'h0002;
  localparam logic [15:0] EVT_DF_LEN = 16'h000C;
  localparam logic [15:0] EVT_PKT_LEN = 16'h0012;
  // event identifiers
  localparam logic [15:0] EID_FIRST = 16'hA4D9;
  localparam logic [15:0] EID_MIN = 16'hA474;
  localparam logic [15:0] EID_MAX = 16'hA604;
  localparam logic [15:0] EID_UPLOAD_FAIL = 16'hA414;
  localparam logic [15:0] EID_DEFAULT_INIT = 16'hA415;
  // dump prefix
  localparam logic [7:0] MEM_SEL = 8'hC0;
  localparam logic [7:0] BLOCK_CNT = 8'h01;
  localparam logic [2:0] PRE_FIRST_STD = 3'h0;
  localparam logic [2:0] PRE_FIRST_BOOT = 3'h2;
  localparam logic [2:0] PRE_LAST = 3'h7;
  localparam logic [15:0] PRE_STD = 16'h0008;
  localparam logic [15:0] PRE_BOOT = 16'h0006;
  localparam logic [15:0] MAX_WORDS = 16'h07FC;
  localparam logic [15:0] BOOT_SHORT = 16'h0003;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0002;
  // software states and framer states
  typedef enum logic [1:0] {
    SW_INIT = 2'b00,
    SW_BOOT = 2'b01,
    SW_UPLOAD = 2'b10,
    SW_PREOBS = 2'b11
  } etf_sw_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_EID = 3'b010,
    ST_PRE = 3'b011,
    ST_RD = 3'b100,
    ST_HI = 3'b101,
    ST_LO = 3'b110
  } etf_state_t;
endpackage : etf_pkg

// file: design/etf_seq_counter.sv
// wrapping packet sequence counter
`timescale 1ns/1ns
module etf_seq_counter
  import etf_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic srst_i, // sync reset
  input wire logic inc_i, // count one packet
  output logic [SEQ_W-1:0] count_o // current count
);
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      count_o <= SEQ_RST;
    else if (inc_i)
      count_o <= (count_o == SEQ_MAX) ? SEQ_RST : count_o + 14'h0001;
  end
endmodule : etf_seq_counter

// file: design/etf_framer.sv
// event and memory dump telemetry packet framer
// Functional notes
// - 14-bit event sequence count in header
// - event packet 18 bytes, 12-byte data field
// - identifier is unsigned 16 bits, from A4D9
// - generic identifiers limited to 42100..42500
// - anomaly gives service 5 subtype 2 packet
// - failed upload reports identifier A414
// - failed upload commits nothing to memory
// - init without command reports A415
// - then enter pre-observation with defaults
// - dump starts selector 192, block count
// - address, length, then up to 2044 words
// - one contiguous segment per dump request
// - boot/upload drop selector and count bytes
// - boot/upload data starts with address MSW
// - boot/upload send three words fewer
// - pre-observation uses full standard layout
// - header carries elapsed time at generation
`timescale 1ns/1ns
module etf_framer
  import etf_pkg::*;
(
  input wire logic mclk_i, // 20 MHz clock
  input wire logic srst_i, // sync reset
  input wire logic [47:0] elapsed_time_i, // spacecraft elapsed time
  input wire logic anomaly_i, // generic anomaly pulse
  input wire logic [15:0] anomaly_eid_i, // its event identifier
  input wire logic upload_done_i, // upload sequence ended pulse
  input wire logic upload_ok_i, // all upload conditions met
  input wire logic init_tc_i, // valid init command pulse
  input wire logic init_end_i, // init state over pulse
  input wire logic dump_req_i, // dump request pulse
  input wire logic [31:0] dump_addr_i, // requested start byte address
  input wire logic [15:0] dump_len_i, // requested words
  input wire logic [1:0] sw_state_i, // software state
  input wire logic [15:0] mem_data_i, // memory word, one cycle after read
  input wire logic tx_ready_i, // sink takes byte
  output logic [7:0] tx_data_o, // packet byte
  output logic tx_valid_o, // byte valid
  output logic tx_last_o, // last byte of packet
  output logic mem_rd_o, // memory read strobe
  output logic [31:0] mem_addr_o, // memory byte address
  output logic image_commit_o, // commit uploaded image pulse
  output logic default_settings_o, // apply defaults, go pre-obs pulse
  output logic dump_busy_o // dump request would be ignored
);
  etf_state_t state_q;
  logic [3:0] idx_q;
  logic [2:0] pre_q;
  logic [15:0] words_q;
  logic [15:0] wcnt_q;
  logic [31:0] addr_q;
  logic [15:0] len_q;
  logic [15:0] eid_q;
  logic [15:0] gen_eid_q;
  logic [47:0] time_q;
  logic [15:0] word_q;
  logic dump_q, boot_q, rd_q;
  logic pend_fail_q, pend_init_q, pend_gen_q, init_seen_q;
  logic dump_pend_q;
  logic [31:0] req_addr_q;
  logic [15:0] req_len_q;
  logic req_boot_q;
  logic [SEQ_W-1:0] evt_seq, dmp_seq;
  logic adv, emit, last_d, take_evt, take_dump;
  logic fail_set, init_set, gen_set;
  logic [7:0] byte_d;
  logic [15:0] words_d;
  logic [12:0] bcnt_q;

  function automatic logic eid_ok(input logic [15:0] e);
    eid_ok = (e >= EID_MIN) && (e <= EID_MAX);
  endfunction : eid_ok

  function automatic logic [15:0] clamp_words(input logic [15:0] n, input logic bt);
    logic [15:0] m;
    m = bt ? ((n > BOOT_SHORT) ? n - BOOT_SHORT : 16'h0000) : n;
    clamp_words = (m > MAX_WORDS) ? MAX_WORDS : m;
  endfunction : clamp_words

  assign fail_set = upload_done_i & ~upload_ok_i;
  assign init_set = init_end_i & ~(init_seen_q | init_tc_i);
  assign gen_set = anomaly_i & eid_ok(anomaly_eid_i);
  assign take_evt = (state_q == ST_IDLE) & (pend_fail_q | pend_init_q | pend_gen_q);
  assign take_dump = (state_q == ST_IDLE) & ~take_evt & dump_pend_q;
  assign words_d = clamp_words(req_len_q, req_boot_q);
  assign adv = ~tx_valid_o | tx_ready_i;
  assign mem_rd_o = (state_q == ST_RD);
  assign mem_addr_o = addr_q;
  assign dump_busy_o = dump_pend_q;

  // pending events, set wins over clear
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pend_fail_q <= 1'b0;
      pend_init_q <= 1'b0;
      pend_gen_q <= 1'b0;
      gen_eid_q <= EID_FIRST;
    end
    else
    begin
      pend_fail_q <= fail_set | (pend_fail_q & ~take_evt);
      pend_init_q <= init_set | (pend_init_q & ~(take_evt & ~pend_fail_q));
      pend_gen_q <= gen_set | (pend_gen_q & ~(take_evt & ~pend_fail_q & ~pend_init_q));
      if (gen_set)
        gen_eid_q <= anomaly_eid_i;
    end
  end

  // init and upload side effects
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      init_seen_q <= 1'b0;
      image_commit_o <= 1'b0;
      default_settings_o <= 1'b0;
    end
    else
    begin
      init_seen_q <= ~init_end_i & (init_seen_q | init_tc_i);
      image_commit_o <= upload_done_i & upload_ok_i;
      default_settings_o <= init_set;
    end
  end

  // single dump request holder
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      dump_pend_q <= 1'b0;
      req_addr_q <= 32'h0000_0000;
      req_len_q <= 16'h0000;
      req_boot_q <= 1'b0;
    end
    else if (dump_req_i & ~dump_pend_q)
    begin
      dump_pend_q <= 1'b1;
      req_addr_q <= dump_addr_i;
      req_len_q <= dump_len_i;
      req_boot_q <= (sw_state_i == SW_BOOT) || (sw_state_i == SW_UPLOAD);
    end
    else if (take_dump)
      dump_pend_q <= 1'b0;
  end

  etf_seq_counter u_evt_seq (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .inc_i(take_evt),
    .count_o(evt_seq)
  );

  etf_seq_counter u_dmp_seq (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .inc_i(take_dump),
    .count_o(dmp_seq)
  );

  // byte selection
  always_comb
  begin
    byte_d = 8'h00;
    last_d = 1'b0;
    emit = 1'b0;
    unique case (state_q)
      ST_IDLE, ST_RD:
        emit = 1'b0;
      ST_HDR:
      begin
        emit = adv;
        unique case (idx_q)
          4'h0: byte_d = dump_q ? DMP_ID_HI : EVT_ID_HI;
          4'h1: byte_d = dump_q ? DMP_ID_LO : EVT_ID_LO;
          4'h2: byte_d = {SEQ_FLAGS, (dump_q ? dmp_seq[13:8] : evt_seq[13:8])};
          4'h3: byte_d = dump_q ? dmp_seq[7:0] : evt_seq[7:0];
          4'h4: byte_d = len_q[15:8];
          4'h5: byte_d = len_q[7:0];
          4'h6: byte_d = time_q[47:40];
          4'h7: byte_d = time_q[39:32];
          4'h8: byte_d = time_q[31:24];
          4'h9: byte_d = time_q[23:16];
          4'hA: byte_d = time_q[15:8];
          4'hB: byte_d = time_q[7:0];
          4'hC: byte_d = DFH_PUS;
          4'hD: byte_d = dump_q ? DMP_SVC : EVT_SVC;
          4'hE: byte_d = dump_q ? DMP_SUB : EVT_SUB;
          4'hF: byte_d = DFH_SPARE;
        endcase
      end
      ST_EID:
      begin
        emit = adv;
        byte_d = idx_q[0] ? eid_q[7:0] : eid_q[15:8];
        last_d = idx_q[0];
      end
      ST_PRE:
      begin
        emit = adv;
        unique case (pre_q)
          3'h0: byte_d = MEM_SEL;
          3'h1: byte_d = BLOCK_CNT;
          3'h2: byte_d = addr_q[31:24];
          3'h3: byte_d = addr_q[23:16];
          3'h4: byte_d = addr_q[15:8];
          3'h5: byte_d = addr_q[7:0];
          3'h6: byte_d = words_q[15:8];
          3'h7: byte_d = words_q[7:0];
        endcase
        last_d = (pre_q == PRE_LAST) && (words_q == 16'h0000);
      end
      ST_HI:
      begin
        emit = adv & ~rd_q;
        byte_d = word_q[15:8];
      end
      ST_LO:
      begin
        emit = adv;
        byte_d = word_q[7:0];
        last_d = (wcnt_q == 16'h0001);
      end
      default:
        emit = 1'b0;
    endcase
  end

  // sequencing
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
      pre_q <= PRE_FIRST_STD;
      dump_q <= 1'b0;
      boot_q <= 1'b0;
      eid_q <= EID_FIRST;
      len_q <= 16'h0000;
      time_q <= 48'h0000_0000_0000;
      addr_q <= 32'h0000_0000;
      words_q <= 16'h0000;
      wcnt_q <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          idx_q <= 4'h0;
          time_q <= elapsed_time_i;
          if (take_evt)
          begin
            state_q <= ST_HDR;
            dump_q <= 1'b0;
            eid_q <= pend_fail_q ? EID_UPLOAD_FAIL :
                     (pend_init_q ? EID_DEFAULT_INIT : gen_eid_q);
            len_q <= EVT_DF_LEN - 16'h0001;
          end
          else if (take_dump)
          begin
            state_q <= ST_HDR;
            dump_q <= 1'b1;
            boot_q <= req_boot_q;
            addr_q <= req_addr_q;
            words_q <= words_d;
            wcnt_q <= words_d;
            len_q <= 16'(DFH_LEN + (req_boot_q ? PRE_BOOT : PRE_STD) + (words_d << 1)
                         - 16'h0001);
          end
        end
        ST_HDR:
          if (emit)
          begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == HDR_LAST)
            begin
              state_q <= dump_q ? ST_PRE : ST_EID;
              pre_q <= boot_q ? PRE_FIRST_BOOT : PRE_FIRST_STD;
            end
          end
        ST_EID:
          if (emit)
          begin
            idx_q <= idx_q + 4'h1;
            if (idx_q[0])
              state_q <= ST_IDLE;
          end
        ST_PRE:
          if (emit)
          begin
            pre_q <= pre_q + 3'h1;
            if (pre_q == PRE_LAST)
              state_q <= (words_q == 16'h0000) ? ST_IDLE : ST_RD;
          end
        ST_RD:
          state_q <= ST_HI;
        ST_HI:
          if (emit)
            state_q <= ST_LO;
        ST_LO:
          if (emit)
          begin
            wcnt_q <= wcnt_q - 16'h0001;
            addr_q <= addr_q + ADDR_STEP;
            state_q <= (wcnt_q == 16'h0001) ? ST_IDLE : ST_RD;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // memory word capture
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rd_q <= 1'b0;
      word_q <= 16'h0000;
    end
    else
    begin
      rd_q <= mem_rd_o;
      if (rd_q)
        word_q <= mem_data_i;
    end
  end

  // output byte register
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
    end
    else if (emit)
    begin
      tx_data_o <= byte_d;
      tx_valid_o <= 1'b1;
      tx_last_o <= last_d;
    end
    else if (tx_ready_i)
      tx_valid_o <= 1'b0;
  end

  // emitted byte count, checking aid
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || (state_q == ST_IDLE))
      bcnt_q <= 13'h0000;
    else if (emit)
      bcnt_q <= bcnt_q + 13'h0001;
  end

  property p_evt_len;
    @(posedge mclk_i) disable iff (srst_i)
      (state_q == ST_EID && emit && idx_q[0]) |-> (bcnt_q == 13'(EVT_PKT_LEN - 16'h0001));
  endproperty
  a_evt_len: assert property (p_evt_len) else $error("event packet not 18 bytes");

  property p_eid_range;
    @(posedge mclk_i) disable iff (srst_i)
      take_evt && !pend_fail_q && !pend_init_q ##1 1 |-> eid_ok(eid_q);
  endproperty
  a_eid_range: assert property (p_eid_range) else $error("identifier out of range");

  property p_fail_eid;
    @(posedge mclk_i) disable iff (srst_i)
      (fail_set && state_q == ST_IDLE && !take_evt && !dump_pend_q)
        |=> ##1 (eid_q == EID_UPLOAD_FAIL);
  endproperty
  a_fail_eid: assert property (p_fail_eid) else $error("upload failure not reported");

  property p_no_commit;
    @(posedge mclk_i) disable iff (srst_i)
      image_commit_o |-> $past(upload_ok_i) && $past(upload_done_i);
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("commit after failed upload");

  property p_defaults;
    @(posedge mclk_i) disable iff (srst_i)
      init_end_i && !init_seen_q && !init_tc_i |=> default_settings_o && pend_init_q;
  endproperty
  a_defaults: assert property (p_defaults) else $error("default init not applied");

  property p_dump_cause;
    @(posedge mclk_i) disable iff (srst_i)
      (state_q == ST_IDLE) ##1 (state_q == ST_HDR && dump_q) |-> $past(dump_pend_q);
  endproperty
  a_dump_cause: assert property (p_dump_cause) else $error("dump without request");

  property p_boot_skip;
    @(posedge mclk_i) disable iff (srst_i)
      (state_q == ST_PRE && boot_q) |-> (pre_q >= PRE_FIRST_BOOT);
  endproperty
  a_boot_skip: assert property (p_boot_skip) else $error("boot dump sent selector");

  property p_boot_msw;
    @(posedge mclk_i) disable iff (srst_i)
      (state_q == ST_PRE && boot_q && pre_q == PRE_FIRST_BOOT && emit)
        |=> (tx_data_o == addr_q[31:24]);
  endproperty
  a_boot_msw: assert property (p_boot_msw) else $error("boot dump not address first");

  property p_words;
    @(posedge mclk_i) disable iff (srst_i)
      take_dump |=> (words_q == clamp_words($past(req_len_q), $past(req_boot_q)))
        && (words_q <= MAX_WORDS);
  endproperty
  a_words: assert property (p_words) else $error("dump word count wrong");
endmodule : etf_framer

// file: test/etf_sink_model.sv
// byte sink and memory model on the far side of the framer
`timescale 1ns/1ns
module etf_sink_model
(
  input wire logic mclk_i, // clock
  input wire logic slow_i, // stall every other cycle
  input wire logic [7:0] tx_data_i, // packet byte
  input wire logic tx_valid_i, // byte valid
  input wire logic tx_last_i, // last byte of packet
  input wire logic mem_rd_i, // memory read strobe
  input wire logic [31:0] mem_addr_i, // memory byte address
  output logic tx_ready_o, // sink takes byte
  output logic [15:0] mem_data_o // memory word
);
  logic [7:0] got[$];
  bit lasts[$];
  logic [15:0] held_q = 16'h0000;
  logic ready_q = 1'b1;
  assign tx_ready_o = ready_q;
  // word valid in the read cycle and the next, scrambled after that
  assign mem_data_o = mem_rd_i ? (mem_addr_i[15:0] ^ 16'h5AA5) : held_q;
  always @(posedge mclk_i)
  begin
    ready_q <= slow_i ? ~ready_q : 1'b1;
    held_q <= mem_rd_i ? (mem_addr_i[15:0] ^ 16'h5AA5) : ~held_q;
    // bytes only logged, nothing acted on
    if (tx_valid_i && ready_q)
    begin
      got.push_back(tx_data_i);
      lasts.push_back(tx_last_i);
    end
  end
endmodule : etf_sink_model

// file: test/testbench.sv
// self-checking bench for the telemetry framer
`timescale 1ns/1ns
module testbench;
  import etf_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [47:0] tval = 48'h0;
  logic anomaly_i = 1'b0;
  logic [15:0] event_identifier = 16'h0;
  logic upload_done_i = 1'b0;
  logic upload_ok_i = 1'b0;
  logic init_tc_i = 1'b0;
  logic init_end_i = 1'b0;
  logic dump_req_i = 1'b0;
  logic [31:0] dump_addr_i = 32'h0;
  logic [15:0] dump_len_i = 16'h0;
  logic [1:0] sw_state_i = SW_PREOBS;
  logic slow_i = 1'b0;
  logic [15:0] mem_data_i;
  logic tx_ready_i;
  logic [7:0] tx_data_o;
  logic tx_valid_o, tx_last_o, mem_rd_o, image_commit_o, default_settings_o, dump_busy_o;
  logic [31:0] mem_addr_o;
  logic [7:0] exp[$];
  logic [13:0] ev_seq = 14'h0;
  logic [13:0] dm_seq = 14'h0;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 mclk_i = ~mclk_i;

  etf_framer etf_framer_i (.mclk_i(mclk_i), .srst_i(srst_i), .elapsed_time_i(tval),
    .anomaly_i(anomaly_i), .anomaly_eid_i(event_identifier), .upload_done_i(upload_done_i),
    .upload_ok_i(upload_ok_i), .init_tc_i(init_tc_i), .init_end_i(init_end_i),
    .dump_req_i(dump_req_i), .dump_addr_i(dump_addr_i), .dump_len_i(dump_len_i),
    .sw_state_i(sw_state_i), .mem_data_i(mem_data_i), .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .image_commit_o(image_commit_o),
    .default_settings_o(default_settings_o), .dump_busy_o(dump_busy_o));

  etf_sink_model etf_sink_model_i (.mclk_i(mclk_i), .slow_i(slow_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .tx_ready_o(tx_ready_i), .mem_data_o(mem_data_i));

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    cmp_count++;
    if (got !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  // mask order: anomaly, upload done, init command, init end, dump request
  task automatic fire(input logic [4:0] m);
    @(posedge mclk_i);
    #1;
    {anomaly_i, upload_done_i, init_tc_i, init_end_i, dump_req_i} = m;
    @(posedge mclk_i);
    #1;
    {anomaly_i, upload_done_i, init_tc_i, init_end_i, dump_req_i} = 5'h00;
  endtask : fire

  task automatic hdr(input logic dump, input logic [15:0] len, input logic [7:0] svc, sub);
    logic [13:0] s;
    // counter steps at packet start, packet carries the stepped value
    if (dump)
      dm_seq++;
    else
      ev_seq++;
    s = dump ? dm_seq : ev_seq;
    exp.push_back(dump ? DMP_ID_HI : EVT_ID_HI);
    exp.push_back(dump ? DMP_ID_LO : EVT_ID_LO);
    exp.push_back({SEQ_FLAGS, s[13:8]});
    exp.push_back(s[7:0]);
    exp.push_back(len[15:8]);
    exp.push_back(len[7:0]);
    for (int i = 5; i >= 0; i--)
      exp.push_back(tval[i*8 +: 8]);
    exp.push_back(DFH_PUS);
    exp.push_back(svc);
    exp.push_back(sub);
    exp.push_back(DFH_SPARE);
  endtask : hdr

  task automatic exp_evt(input logic [15:0] id);
    hdr(1'b0, EVT_PKT_LEN - 16'h0007, EVT_SVC, EVT_SUB);
    exp.push_back(id[15:8]);
    exp.push_back(id[7:0]);
  endtask : exp_evt

  task automatic check_pkt();
    int n;
    n = 0;
    while (etf_sink_model_i.got.size() < exp.size() && n < 20000)
    begin
      @(posedge mclk_i);
      n++;
    end
    #1;
    chk({15'h0, etf_sink_model_i.got.size() >= exp.size()}, 16'h0001);
    foreach (exp[i])
      if (etf_sink_model_i.got.size() > 0)
      begin
        chk({8'h00, etf_sink_model_i.got.pop_front()}, {8'h00, exp[i]});
        chk({15'h0, etf_sink_model_i.lasts.pop_front()}, {15'h0, i == exp.size() - 1});
      end
    exp.delete();
  endtask : check_pkt

  task automatic no_pkt();
    repeat (40) @(posedge mclk_i);
    #1;
    chk({15'h0, etf_sink_model_i.got.size() == 0}, 16'h0001);
  endtask : no_pkt

  task automatic t_events();
    logic [15:0] ids[4];
    ids = '{EID_MIN - 16'h0001, EID_MAX + 16'h0001, EID_MIN, EID_MAX};
    tval = 48'h123456789ABC;
    event_identifier = EID_FIRST;
    fire(5'h10);
    exp_evt(EID_FIRST);
    check_pkt();
    for (int i = 0; i < 4; i++)
    begin
      event_identifier = ids[i];
      fire(5'h10);
      if (i < 2)
        no_pkt();
      else
      begin
        exp_evt(ids[i]);
        check_pkt();
      end
    end
    $display("events test done");
  endtask : t_events

  task automatic t_upload();
    tval = 48'hFEDCBA987654;
    event_identifier = 16'hA500;
    upload_ok_i = 1'b0;
    fire(5'h18);
    chk({15'h0, image_commit_o}, 16'h0000);
    exp_evt(EID_UPLOAD_FAIL);
    check_pkt();
    exp_evt(16'hA500);
    check_pkt();
    upload_ok_i = 1'b1;
    fire(5'h08);
    chk({15'h0, image_commit_o}, 16'h0001);
    @(posedge mclk_i);
    #1;
    chk({15'h0, image_commit_o}, 16'h0000);
    no_pkt();
    $display("upload test done");
  endtask : t_upload

  task automatic t_init();
    fire(5'h02);
    chk({15'h0, default_settings_o}, 16'h0001);
    exp_evt(EID_DEFAULT_INIT);
    check_pkt();
    fire(5'h04);
    fire(5'h02);
    chk({15'h0, default_settings_o}, 16'h0000);
    no_pkt();
    $display("init test done");
  endtask : t_init

  task automatic run_dump(input logic [1:0] st, input logic [15:0] n, input logic [31:0] a,
    input logic slow);
    logic boot;
    logic [15:0] w;
    logic [15:0] d;
    boot = (st == SW_BOOT) || (st == SW_UPLOAD);
    w = boot ? ((n > BOOT_SHORT) ? n - BOOT_SHORT : 16'h0000) : n;
    if (w > MAX_WORDS)
      w = MAX_WORDS;
    sw_state_i = st;
    dump_addr_i = a;
    dump_len_i = n;
    slow_i = slow;
    event_identifier = EID_FIRST;
    // event goes first, so the dump request stays held during it
    fire(5'h11);
    chk({15'h0, dump_busy_o}, 16'h0001);
    dump_addr_i = a + 32'h0000_0100;
    fire(5'h01);
    chk({15'h0, dump_busy_o}, 16'h0001);
    exp_evt(EID_FIRST);
    check_pkt();
    hdr(1'b1, DFH_LEN + (boot ? PRE_BOOT : PRE_STD) + (w << 1) - 16'h0001, DMP_SVC, DMP_SUB);
    if (!boot)
    begin
      exp.push_back(MEM_SEL);
      exp.push_back(BLOCK_CNT);
    end
    for (int i = 3; i >= 0; i--)
      exp.push_back(a[i*8 +: 8]);
    exp.push_back(w[15:8]);
    exp.push_back(w[7:0]);
    for (int i = 0; i < w; i++)
    begin
      d = (a[15:0] + 16'(2 * i)) ^ 16'h5AA5;
      exp.push_back(d[15:8]);
      exp.push_back(d[7:0]);
    end
    check_pkt();
    no_pkt();
    chk({15'h0, dump_busy_o}, 16'h0000);
    $display("dump test done");
  endtask : run_dump

  initial
  begin
    repeat (6) @(posedge mclk_i);
    #1;
    srst_i = 1'b0;
    chk({10'h0, tx_valid_o, tx_last_o, mem_rd_o, image_commit_o, default_settings_o,
      dump_busy_o}, 16'h0000);
    t_events();
    t_upload();
    t_init();
    tval = 48'h00000000BEEF;
    // boot and upload requests carry three extra words
    run_dump(SW_PREOBS, 16'h0003, 32'h0000_1000, 1'b1);
    run_dump(SW_BOOT, 16'h0005, 32'h0002_0040, 1'b1);
    run_dump(SW_UPLOAD, 16'h0002, 32'h0003_0000, 1'b0);
    run_dump(SW_PREOBS, 16'h0802, 32'h00F0_0000, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
